// *** core/gpport_pkg.sv ***
// Package: register map, field positions and carrier types of the dual GPIO port block
package gpport_pkg;

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int PINS = 8;
	localparam int AW = 12;

	// ----------------------------------------
	// Window bases inside the APB space
	// ----------------------------------------
	localparam logic [11:0] FIRST_BASE = 12'h000;
	localparam logic [11:0] SECOND_BASE = 12'h040;
	localparam logic [11:0] WIN_MASK = 12'hfc0;
	localparam logic [11:0] BASE_FIRST_HI = 12'h000;
	localparam logic [11:0] BASE_SECOND_HI = 12'h040;

	// ----------------------------------------
	// Register offsets from a port base
	// ----------------------------------------
	localparam logic [5:0] OFF_DATA = 6'h00;
	localparam logic [5:0] OFF_OUT_EN = 6'h04;
	localparam logic [5:0] OFF_FUNC = 6'h08;
	localparam logic [5:0] OFF_OPEN_DRAIN = 6'h28;
	localparam logic [5:0] OFF_PULLUP = 6'h2c;
	localparam logic [5:0] OFF_IN_EN = 6'h38;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_SECOND_PULLUP = 8'h01;

	// ----------------------------------------
	// First port function bit positions
	// ----------------------------------------
	localparam int FB_SER0_TX = 0;
	localparam int FB_SER0_RX = 1;
	localparam int FB_SER0_CLK = 2;
	localparam int FB_EXT_EXTERNAL_INTERRUPT_FOUR = 3;
	localparam int FB_SER2_TX = 4;
	localparam int FB_SER2_RX = 5;
	localparam int FB_SER2_CLK = 6;
	localparam int FB_TIMER8 = 7;

	// Boot strap pin index on the second port
	localparam int BOOT_PIN = 0;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic {
		GPPORT_BOOT_LOADER,
		GPPORT_BOOT_FLASH
	} gpport_boot_t;

	typedef enum logic [1:0] {
		GPPORT_ST_STRAP,
		GPPORT_ST_RUN
	} gpport_state_t;

	// Pin-facing drive group of one port
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull_en;
		logic [7:0] in_en;
	} gpport_pad_t;

	// Peripheral-side signals of the first port
	typedef struct packed {
		logic timer_eight_output;
		logic serial_two_clock;
		logic serial_two_transmit;
		logic serial_zero_clock;
		logic serial_zero_transmit;
	} gpport_alt_out_t;

	typedef struct packed {
		logic [7:0] oe;
	} gpport_alt_oe_t;

	// Whole block state
	typedef struct packed {
		gpport_state_t state;
		logic boot_mode;
		logic boot_done;
		logic [7:0] f_func;
		logic [7:0] f_od;
		logic [7:0] f_pu;
		logic [7:0] f_ie;
		logic [7:0] f_data;
		logic [7:0] f_oe;
		logic [7:0] s_data;
		logic [7:0] s_oe;
		logic [7:0] s_func;
		logic [7:0] s_pu;
		logic [7:0] s_ie;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		gpport_pad_t f_pad;
		gpport_pad_t s_pad;
		logic [7:0] f_alt_in;
		logic [7:0] s_alt_in;
		logic ext_external_interrupt_four;
	} gpport_regs_t;

endpackage

// *** core/gpport_top.sv ***
// Dual eight-pin GPIO port with APB registers, alternate functions and boot strap
// Function
// - Eight pins per port; per-pin input and output enables.
// - Second port pins feed timer inputs and the boot mode select.
// - During reset the strap pin input buffer and pull-up are on.
// - Strap high at reset release selects single mode from flash.
// - Strap low at reset release selects single boot loader mode.
// - After reset second port pins are plain, inputs and outputs off.
// - After reset second port pull-up on pin 0 only.
// - Second port decodes data 0x00, output enable 0x04, function 0x08.
// - Second port decodes pull-up 0x2c and input enable 0x38.
// - Second port data: bits 7-0, upper bits read zero, reset zero.
// - First port open-drain bits: 0 push-pull, 1 open-drain, reset zero.
// - First port pull-up bits enable pull-ups, reset zero.
// - First port input enable bits enable input buffers, reset zero.
// - First port function: 0 plain, bit 7 timer out, bit 3 interrupt 4.
// - Function bits 6-4 route serial two, bits 2-0 serial zero.
// - First port registers: bits 31-8 read zero, 7-0 read/write.
// - First port decodes function 0x08, open-drain 0x28, pull-up 0x2c, input 0x38.
// - Interrupt 4 delivered whenever its input buffer is on, outside stop.
`timescale 1ns/100ps

module gpport_top (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic stop_mode,
	input wire logic [7:0] first_pin_in,
	output logic [7:0] first_pin_out,
	output logic [7:0] first_pin_oe,
	output logic [7:0] first_pin_pullup,
	output logic [7:0] first_pin_in_en,
	input wire logic [7:0] second_pin_in,
	output logic [7:0] second_pin_out,
	output logic [7:0] second_pin_oe,
	output logic [7:0] second_pin_pullup,
	output logic [7:0] second_pin_in_en,
	input wire gpport_pkg::gpport_alt_out_t alt_out,
	output logic [7:0] first_alt_in,
	output logic [7:0] timer_input,
	output logic external_interrupt_four,
	output logic boot_from_flash,
	output logic boot_valid
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [7:0] f_sync1_q;
	logic [7:0] f_sync2_q;
	logic [7:0] s_sync1_q;
	logic [7:0] s_sync2_q;

	// No reset: the strap level must reach stage two while reset is low
	always_ff @(posedge mclk) begin
		f_sync1_q <= first_pin_in;
		f_sync2_q <= f_sync1_q;
		s_sync1_q <= second_pin_in;
		s_sync2_q <= s_sync1_q;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [5:0] win_off(input logic [11:0] a);
		win_off = a[5:0];
	endfunction

	function automatic logic [31:0] zext(input logic [7:0] v);
		zext = {24'h000000, v};
	endfunction

	// Pad drive for one pin: open-drain only pulls low
	function automatic logic pad_oe(input logic en, input logic od, input logic val);
		pad_oe = en & (~od | ~val);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	gpport_pkg::gpport_regs_t st_q;
	gpport_pkg::gpport_regs_t st_d;

	logic [7:0] f_drv_val;
	logic [7:0] f_drv_en;
	logic [5:0] off;
	logic hit_first;
	logic hit_second;
	logic setup;
	logic wr;
	logic rd;
	logic mapped;
	logic [31:0] rdata;

	always_comb begin
		st_d = st_q;
		off = win_off(paddr);
		hit_first = (paddr & gpport_pkg::WIN_MASK) == gpport_pkg::FIRST_BASE;
		hit_second = (paddr & gpport_pkg::WIN_MASK) == gpport_pkg::SECOND_BASE;
		setup = psel & ~penable;
		// Write lands at the edge where the master samples ready high
		wr = psel & penable & pwrite & st_q.pready;
		rd = setup & ~pwrite;
		mapped = 1'b0;
		rdata = 32'h00000000;

		// Boot strap sampling after reset release
		case (st_q.state)
			gpport_pkg::GPPORT_ST_STRAP: begin
				st_d.boot_mode = s_sync2_q[gpport_pkg::BOOT_PIN];
				st_d.boot_done = 1'b1;
				st_d.state = gpport_pkg::GPPORT_ST_RUN;
			end
			default: begin
				st_d.state = gpport_pkg::GPPORT_ST_RUN;
			end
		endcase

		// Address decode, first port
		if (hit_first && off == gpport_pkg::OFF_DATA) begin
			mapped = 1'b1;
			rdata = zext((st_q.f_data & ~st_q.f_ie) | (f_sync2_q & st_q.f_ie));
			if (wr) st_d.f_data = pwdata[7:0];
		end else if (hit_first && off == gpport_pkg::OFF_OUT_EN) begin
			mapped = 1'b1;
			rdata = zext(st_q.f_oe);
			if (wr) st_d.f_oe = pwdata[7:0];
		end else if (hit_first && off == gpport_pkg::OFF_FUNC) begin
			mapped = 1'b1;
			rdata = zext(st_q.f_func);
			if (wr) st_d.f_func = pwdata[7:0];
		end else if (hit_first && off == gpport_pkg::OFF_OPEN_DRAIN) begin
			mapped = 1'b1;
			rdata = zext(st_q.f_od);
			if (wr) st_d.f_od = pwdata[7:0];
		end else if (hit_first && off == gpport_pkg::OFF_PULLUP) begin
			mapped = 1'b1;
			rdata = zext(st_q.f_pu);
			if (wr) st_d.f_pu = pwdata[7:0];
		end else if (hit_first && off == gpport_pkg::OFF_IN_EN) begin
			mapped = 1'b1;
			rdata = zext(st_q.f_ie);
			if (wr) st_d.f_ie = pwdata[7:0];
		// Address decode, second port
		end else if (hit_second && off == gpport_pkg::OFF_DATA) begin
			mapped = 1'b1;
			rdata = zext((st_q.s_data & ~st_q.s_ie) | (s_sync2_q & st_q.s_ie));
			if (wr) st_d.s_data = pwdata[7:0];
		end else if (hit_second && off == gpport_pkg::OFF_OUT_EN) begin
			mapped = 1'b1;
			rdata = zext(st_q.s_oe);
			if (wr) st_d.s_oe = pwdata[7:0];
		end else if (hit_second && off == gpport_pkg::OFF_FUNC) begin
			mapped = 1'b1;
			rdata = zext(st_q.s_func);
			if (wr) st_d.s_func = pwdata[7:0];
		end else if (hit_second && off == gpport_pkg::OFF_PULLUP) begin
			mapped = 1'b1;
			rdata = zext(st_q.s_pu);
			if (wr) st_d.s_pu = pwdata[7:0];
		end else if (hit_second && off == gpport_pkg::OFF_IN_EN) begin
			mapped = 1'b1;
			rdata = zext(st_q.s_ie);
			if (wr) st_d.s_ie = pwdata[7:0];
		end

		// APB answer: one access cycle, error on unmapped or reserved address
		st_d.pready = setup;
		st_d.pslverr = setup & ~mapped;
		if (rd) st_d.prdata = rdata;
		else if (setup) st_d.prdata = 32'h00000000;

		// First port output mux: function bit steers the peripheral onto the pin
		f_drv_val = st_q.f_data;
		f_drv_en = st_q.f_oe;
		if (st_q.f_func[gpport_pkg::FB_TIMER8]) begin
			f_drv_val[gpport_pkg::FB_TIMER8] = alt_out.timer_eight_output;
			f_drv_en[gpport_pkg::FB_TIMER8] = 1'b1;
		end
		if (st_q.f_func[gpport_pkg::FB_SER2_CLK]) begin
			f_drv_val[gpport_pkg::FB_SER2_CLK] = alt_out.serial_two_clock;
			f_drv_en[gpport_pkg::FB_SER2_CLK] = 1'b1;
		end
		if (st_q.f_func[gpport_pkg::FB_SER2_TX]) begin
			f_drv_val[gpport_pkg::FB_SER2_TX] = alt_out.serial_two_transmit;
			f_drv_en[gpport_pkg::FB_SER2_TX] = 1'b1;
		end
		if (st_q.f_func[gpport_pkg::FB_SER0_CLK]) begin
			f_drv_val[gpport_pkg::FB_SER0_CLK] = alt_out.serial_zero_clock;
			f_drv_en[gpport_pkg::FB_SER0_CLK] = 1'b1;
		end
		if (st_q.f_func[gpport_pkg::FB_SER0_TX]) begin
			f_drv_val[gpport_pkg::FB_SER0_TX] = alt_out.serial_zero_transmit;
			f_drv_en[gpport_pkg::FB_SER0_TX] = 1'b1;
		end

		// First port pads
		st_d.f_pad.out = f_drv_val & ~st_q.f_od;
		for (int i = 0; i < gpport_pkg::PINS; i++) begin
			st_d.f_pad.oe[i] = pad_oe(f_drv_en[i], st_q.f_od[i], f_drv_val[i]);
		end
		st_d.f_pad.pull_en = st_q.f_pu;
		st_d.f_pad.in_en = st_q.f_ie;

		// Second port pads
		st_d.s_pad.out = st_q.s_data;
		st_d.s_pad.oe = st_q.s_oe;
		st_d.s_pad.pull_en = st_q.s_pu;
		st_d.s_pad.in_en = st_q.s_ie;

		// Peripheral inputs, gated by function select and input buffer; interrupt 4 gated by function select only in stop
		st_d.f_alt_in = f_sync2_q & st_q.f_func & st_q.f_ie;
		st_d.s_alt_in = s_sync2_q & st_q.s_func & st_q.s_ie;
		st_d.ext_external_interrupt_four = ~stop_mode & st_q.f_ie[gpport_pkg::FB_EXT_EXTERNAL_INTERRUPT_FOUR]
			& f_sync2_q[gpport_pkg::FB_EXT_EXTERNAL_INTERRUPT_FOUR];
		if (stop_mode) begin
			st_d.ext_external_interrupt_four = st_q.f_ie[gpport_pkg::FB_EXT_EXTERNAL_INTERRUPT_FOUR]
				& st_q.f_func[gpport_pkg::FB_EXT_EXTERNAL_INTERRUPT_FOUR]
				& f_sync2_q[gpport_pkg::FB_EXT_EXTERNAL_INTERRUPT_FOUR];
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
			st_q.state <= gpport_pkg::GPPORT_ST_STRAP;
			st_q.s_pu <= gpport_pkg::RST_SECOND_PULLUP;
			st_q.s_pad.pull_en <= gpport_pkg::RST_SECOND_PULLUP;
			st_q.s_pad.in_en <= gpport_pkg::RST_SECOND_PULLUP;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	assign first_pin_out = st_q.f_pad.out;
	assign first_pin_oe = st_q.f_pad.oe;
	assign first_pin_pullup = st_q.f_pad.pull_en;
	assign first_pin_in_en = st_q.f_pad.in_en;
	assign second_pin_out = st_q.s_pad.out;
	assign second_pin_oe = st_q.s_pad.oe;
	assign second_pin_pullup = st_q.s_pad.pull_en;
	assign second_pin_in_en = st_q.s_pad.in_en;
	assign first_alt_in = st_q.f_alt_in;
	assign timer_input = st_q.s_alt_in;
	assign external_interrupt_four = st_q.ext_external_interrupt_four;
	assign boot_from_flash = st_q.boot_mode;
	assign boot_valid = st_q.boot_done;

endmodule

// *** testbench/gpport_props.sv ***
// Port checker of the dual GPIO port block
`timescale 1ns/100ps

module gpport_props (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] first_pin_in_en,
	input wire logic external_interrupt_four,
	input wire logic [7:0] second_pin_in_en,
	input wire logic [7:0] timer_input,
	input wire logic boot_from_flash,
	input wire logic boot_valid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	chk_pready_one: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	chk_pready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_err_gate: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_err_zero: assert property (pslverr |-> prdata == 32'h0)
		else $error("error with read data");
	chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_boot_hold: assert property (boot_valid |=> boot_valid)
		else $error("boot valid dropped");
	chk_boot_stable: assert property (boot_valid && $past(boot_valid) |-> $stable(boot_from_flash))
		else $error("boot mode changed");
	chk_int_ie: assert property (external_interrupt_four |-> first_pin_in_en[3] || $past(first_pin_in_en[3]))
		else $error("interrupt without input enable");
	chk_timer_ie: assert property ((timer_input & ~(second_pin_in_en | $past(second_pin_in_en))) == 8'h0)
		else $error("timer input without input enable");
	cov_err: cover property (pslverr);
	cov_flash: cover property (boot_valid && boot_from_flash);
	cov_int: cover property (external_interrupt_four);
endmodule

// *** testbench/gpport_board.sv ***
// Board model on the pins of one port
`timescale 1ns/100ps

module gpport_board (
	input wire logic mclk,
	input wire logic [7:0] oe,
	input wire logic [7:0] out,
	input wire logic [7:0] pu_en,
	input wire logic [7:0] drv_en,
	input wire logic [7:0] drv,
	output logic [7:0] pin
);
	logic [7:0] float_q = 8'h5a;

	// Undriven pins without pull-up wander each cycle
	always @(posedge mclk) float_q <= ~float_q;
	always_comb pin = (oe & out) | (~oe & drv_en & drv) | (~oe & ~drv_en & (pu_en | float_q));
endmodule

// *** testbench/gpport_top_test.sv ***
// Testbench of the dual GPIO port block
`timescale 1ns/100ps

module gpport_top_test;
	logic mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, stop_mode = 0, e;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q, rs = 32'hd306ba8e;
	logic pready, pslverr, ext4, bff, bv;
	logic [7:0] fi, fo, foe, fpu, fie, si, so, soe, spu, sie, fa, ti, v;
	logic [7:0] f_en = '0, f_ext = '0, s_en = '0, s_ext = '0;
	gpport_pkg::gpport_alt_out_t alt = '0;
	logic [7:0] mdl [logic [11:0]];
	logic [11:0] al [11] = '{12'h000, 12'h004, 12'h008, 12'h028, 12'h02c, 12'h038,
		12'h040, 12'h044, 12'h048, 12'h06c, 12'h078};
	logic [11:0] bad [3] = '{12'h010, 12'h050, 12'h080};
	int err_total = 0, cmp_count = 0;

	always #12.5 mclk = ~mclk;

	gpport_top dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stop_mode(stop_mode), .first_pin_in(fi), .first_pin_out(fo),
		.first_pin_oe(foe), .first_pin_pullup(fpu), .first_pin_in_en(fie),
		.second_pin_in(si), .second_pin_out(so), .second_pin_oe(soe),
		.second_pin_pullup(spu), .second_pin_in_en(sie), .alt_out(alt),
		.first_alt_in(fa), .timer_input(ti), .external_interrupt_four(ext4),
		.boot_from_flash(bff), .boot_valid(bv));
	gpport_board u_first (.mclk(mclk), .oe(foe), .out(fo), .pu_en(fpu), .drv_en(f_en),
		.drv(f_ext), .pin(fi));
	gpport_board u_second (.mclk(mclk), .oe(soe), .out(so), .pu_en(spu), .drv_en(s_en),
		.drv(s_ext), .pin(si));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction

	task results();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge mclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge mclk);
		penable <= 1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		if (pready !== 1'b1) begin
			err_total++;
			results();
		end
		if (w && mdl.exists(a)) mdl[a] = d[7:0];
	endtask

	task rd(input logic [11:0] a);
		apb(0, a, 32'h0);
		chk($sformatf("reg %h", a), {24'h0, mdl[a]}, q);
		chk("no error", 0, e);
	endtask

	task automatic rst(input logic b);
		int n = 0;
		rstn <= 0;
		{s_en, s_ext} <= {8'h01, 7'h0, b};
		repeat (8) @(posedge mclk);
		chk("reset pullup", 8'h01, spu);
		chk("reset in_en", 8'h01, sie);
		rstn <= 1;
		while (bv !== 1'b1 && n < 10) begin
			@(posedge mclk);
			n++;
		end
		chk("boot valid", 1, bv);
		chk("boot mode", b, bff);
		chk("s oe", 0, soe);
		chk("s pullup", 8'h01, spu);
		chk("s in_en", 0, sie);
		s_en <= 0;
		foreach (al[i]) mdl[al[i]] = 8'(al[i] == 12'h06c);
		$display("test reset done");
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		rst(0);
		foreach (al[i]) rd(al[i]);
		repeat (3) begin
			foreach (al[i]) begin
				if (al[i][5:0] != 6'h00) begin
					apb(1, al[i], rnd());
					rd(al[i]);
				end
			end
		end
		chk("f pullup", mdl[12'h02c], fpu);
		chk("f in_en", mdl[12'h038], fie);
		foreach (bad[i]) begin
			apb(1, bad[i], 32'hff);
			chk("slverr", 1, e);
			apb(0, bad[i], 32'h0);
			chk("err data", 0, q);
		end
		$display("test registers done");
		apb(1, 12'h078, 32'h0);
		apb(1, 12'h044, 32'hff);
		v = 8'(rnd());
		apb(1, 12'h040, {24'h0, v});
		rd(12'h040);
		chk("s out", v, so);
		apb(1, 12'h044, 32'h0);
		v = 8'(rnd());
		{s_en, s_ext} <= {8'hff, v};
		apb(1, 12'h048, 32'hff);
		apb(1, 12'h078, 32'hff);
		repeat (4) @(posedge mclk);
		apb(0, 12'h040, 32'h0);
		chk("s in", v, q);
		chk("timer in", v, ti);
		s_en <= 0;
		apb(1, 12'h008, 32'h0);
		apb(1, 12'h004, 32'hff);
		apb(1, 12'h028, 32'hff);
		v = 8'(rnd());
		apb(1, 12'h000, {24'h0, v});
		repeat (2) @(posedge mclk);
		chk("od oe", 8'(~v), foe);
		chk("od out", 0, fo);
		alt <= 5'h10;
		apb(1, 12'h028, 32'h0);
		apb(1, 12'h008, 32'h80);
		repeat (2) @(posedge mclk);
		chk("timer out", 1, fo[7]);
		apb(1, 12'h008, 32'h0);
		apb(1, 12'h004, 32'h0);
		{f_en, f_ext} <= {8'h08, 8'h08};
		apb(1, 12'h038, 32'h08);
		repeat (4) @(posedge mclk);
		chk("external_interrupt_four", 1, ext4);
		stop_mode <= 1;
		repeat (4) @(posedge mclk);
		chk("external_interrupt_four stop", 0, ext4);
		apb(1, 12'h008, 32'h08);
		repeat (2) @(posedge mclk);
		chk("external_interrupt_four stop fn", 1, ext4);
		chk("alt in", 8'h08, fa);
		apb(1, 12'h008, 32'h0);
		stop_mode <= 0;
		$display("test pins done");
		rst(1);
		results();
	end
endmodule

bind gpport_top gpport_props u_props (.mclk(mclk), .rstn(rstn), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.first_pin_in_en(first_pin_in_en), .external_interrupt_four(external_interrupt_four),
	.second_pin_in_en(second_pin_in_en), .timer_input(timer_input),
	.boot_from_flash(boot_from_flash), .boot_valid(boot_valid));
